// *** rxc_top.sv ***
// Purpose: static config decode, parity and receive clocking of the
//          parallel character interface
// Assumes: clk is the reference clock; characters arrive on clk
// Notes:   settings are caught only during reset and then held
//
// What this block does
// R1 - high parity setting checks tx char, type bits and parity for odd
// R2 - high parity setting drives odd parity over rx char and status bits
// R3 - decoder low passes the raw 10-bit character unmodified
// R4 - outside must hold rx clock source at middle when decoder is low
// R5 - decoder middle uses primary special table, high the alternate table
// R6 - rx clock source low clocks the output register from reference
// R7 - rx clock source low gives delayed reference copies on clock outputs
// R8 - rx clock source middle follows recovered clock, buffer bypassed
// R9 - outside must never set rx clock source high
// R10 - outside sets ternary pins once and leaves them alone
// R11 - a floating ternary pin reads as the middle setting
// R12 - parity low disables checking and floats the rx parity output
// R13 - parity middle with coding on covers only the eight char bits
// R14 - rx clock low with decoder on enables the elasticity buffer
// R15 - each ternary pin decodes to a two-bit setting sampled in reset
// R16 - flag bypass without recovered clock, or rx clock source high
`timescale 1ns/100ps
`default_nettype none
module rxc_top
    import rxc_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // ternary configuration pins
    input  wire rxc_pin_type  parity_control_select,
    input  wire rxc_pin_type  decoder_mode_select,
    input  wire rxc_pin_type  rx_clock_source_select,
    input  wire rxc_pin_type  tx_encoder_mode_select,
    input  wire rxc_pin_type  recovered_clock_rate_select,
    // recovered character clock, sampled as a pin
    input  wire logic         recovered_clock_in,
    // transmit characters from the host
    input  wire logic [7:0]   tx_char,
    input  wire logic [1:0]   tx_char_type,
    input  wire logic         tx_odd_parity_in,
    input  wire logic         tx_valid,
    output logic              tx_parity_error,
    // receive characters from the line side
    input  wire rxc_rxin_type rx_in,
    input  wire logic         rx_in_valid,
    output logic              rx_in_ready,
    // receive characters to the host
    output logic [9:0]        rx_char_out,
    output logic [2:0]        rx_status_bus,
    output logic              rx_out_valid,
    input  wire logic         rx_out_ready,
    output logic              rx_odd_parity_out,
    output logic              rx_odd_parity_oe,
    // receive clock outputs
    output logic              rx_char_clock_out,
    output logic              rx_clock_copy_out,
    // status
    output logic              elastic_buffer_enable,
    output logic              config_error
);
    localparam int LVL_W  = $clog2(DEPTH + 1);
    localparam int SYNC_W = 11;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [SYNC_W-1:0] pin_meta_reg, pin_sync_reg;
    logic [SYNC_W-1:0] pin_raw;
    rxc_pin_type       s_par, s_dec, s_rxck, s_txm, s_rate;
    logic              rec_sync;

    assign pin_raw = {recovered_clock_in, parity_control_select,
                      decoder_mode_select, rx_clock_source_select,
                      tx_encoder_mode_select, recovered_clock_rate_select};
    assign {rec_sync, s_par, s_dec, s_rxck, s_txm, s_rate} = pin_sync_reg;

    // two stages, no reset: they must keep sampling during reset
    always_ff @(posedge clk) begin
        pin_meta_reg <= pin_raw;
        pin_sync_reg <= pin_meta_reg;
    end

    // ************************************************************
    // configuration capture
    // ************************************************************
    rxc_tern_type cfg_par_reg,  cfg_par_next;
    rxc_tern_type cfg_dec_reg,  cfg_dec_next;
    rxc_tern_type cfg_rxck_reg, cfg_rxck_next;
    rxc_tern_type cfg_txm_reg,  cfg_txm_next;
    rxc_tern_type cfg_rate_reg, cfg_rate_next;
    logic         eb_en, bypass, coding_off;

    // settings follow the pins only while reset is held
    always_comb begin
        cfg_par_next  = cfg_par_reg;
        cfg_dec_next  = cfg_dec_reg;
        cfg_rxck_next = cfg_rxck_reg;
        cfg_txm_next  = cfg_txm_reg;
        cfg_rate_next = cfg_rate_reg;
        if (!nrst) begin
            cfg_par_next  = tern_decode(s_par);   // R15 R11
            cfg_dec_next  = tern_decode(s_dec);   // R15 R11
            cfg_rxck_next = tern_decode(s_rxck);  // R15 R11
            cfg_txm_next  = tern_decode(s_txm);   // R15 R11
            cfg_rate_next = tern_decode(s_rate);  // R15 R11
        end
    end

    // no reset branch: the reset value is the sampled pin itself
    always_ff @(posedge clk) begin
        cfg_par_reg  <= cfg_par_next;
        cfg_dec_reg  <= cfg_dec_next;
        cfg_rxck_reg <= cfg_rxck_next;
        cfg_txm_reg  <= cfg_txm_next;
        cfg_rate_reg <= cfg_rate_next;
    end

    assign bypass     = (cfg_dec_reg == TRI_LOW);
    assign eb_en      = (cfg_rxck_reg == TRI_LOW) && !bypass;  // R14 R8
    assign coding_off = (cfg_txm_reg == TRI_LOW) && bypass;

    // ************************************************************
    // transmit parity check
    // ************************************************************
    logic tx_err_reg, tx_err_next;

    // one-cycle error pulse per offered character with even parity; none when parity is low
    always_comb begin
        tx_err_next = 1'b0;
        if (tx_valid) begin
            case (cfg_par_reg)
                TRI_HIGH: tx_err_next = ~^{tx_char, tx_char_type,
                                          tx_odd_parity_in};  // R1
                TRI_MID:  tx_err_next = coding_off
                    ? ~^{tx_char, tx_char_type, tx_odd_parity_in}
                    : ~^{tx_char, tx_odd_parity_in};          // R13
                default:  tx_err_next = 1'b0;                 // R12
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_err_reg <= 1'b0;
        end else begin
            tx_err_reg <= tx_err_next;
        end
    end
    assign tx_parity_error = tx_err_reg;

    // ************************************************************
    // receive decode
    // ************************************************************
    rxc_rxout_type dec_word;

    // raw pass in bypass, otherwise special codes flagged and, with decoder high, mapped through the alternate table
    always_comb begin
        dec_word.chr    = {2'b00, rx_in.data};
        dec_word.status = ST_DATA;
        if (bypass) begin
            dec_word.chr = rx_in.raw;                           // R3
        end else if (rx_in.code_err) begin
            dec_word.status = ST_CODEERR;
        end else if (rx_in.special) begin
            dec_word.status = ST_SPECIAL;
            if (cfg_dec_reg == TRI_HIGH) begin                  // R5
                dec_word.chr = {2'b00,
                    ALT_CODES[rx_in.data[ALT_IDX_W-1:0]]};
            end
        end
    end

    // ************************************************************
    // buffer and output stage
    // ************************************************************
    logic              fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [RXOUT_W-1:0] fifo_out_data;
    logic [LVL_W-1:0]  fifo_level, lvl_next;
    logic              push, pop, direct;
    logic              stage_valid_reg, stage_valid_next;
    rxc_rxout_type     stage_reg, stage_next;
    logic              ready_reg, ready_next;
    logic              par_reg, par_next, oe_reg, oe_next;

    assign push   = rx_in_valid && ready_reg && eb_en && fifo_in_ready;
    assign direct = rx_in_valid && ready_reg && !eb_en;         // R8
    assign fifo_out_ready = eb_en && (!stage_valid_reg || rx_out_ready);
    assign pop    = fifo_out_valid && fifo_out_ready;

    rxc_fifo #(
        .WIDTH (RXOUT_W),
        .DEPTH (DEPTH),
        .LVL_W (LVL_W)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   (dec_word),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    // output register, fed by the buffer or directly whenever the elasticity buffer is off;
    // direct mode only accepts into an empty stage, halving its rate
    always_comb begin
        stage_valid_next = stage_valid_reg;
        stage_next       = stage_reg;
        if (stage_valid_reg && rx_out_ready) begin
            stage_valid_next = 1'b0;
        end
        if (pop) begin                                          // R6
            stage_valid_next = 1'b1;
            stage_next       = rxc_rxout_type'(fifo_out_data);
        end else if (direct) begin
            stage_valid_next = 1'b1;
            stage_next       = dec_word;
        end
        lvl_next = LVL_W'(fifo_level + LVL_W'(push) - LVL_W'(pop));
        ready_next = eb_en ? (lvl_next != LVL_W'(DEPTH))
                           : !stage_valid_next;
        // parity follows the character it will sit beside
        case (cfg_par_reg)
            TRI_HIGH: par_next = ~^{stage_next.chr[7:0],
                                    stage_next.status};         // R2
            TRI_MID:  par_next = ~^stage_next.chr[7:0];         // R13
            default:  par_next = 1'b0;
        endcase
        oe_next = (cfg_par_reg != TRI_LOW);                     // R12
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            stage_valid_reg <= 1'b0;
            stage_reg       <= '0;
            ready_reg       <= 1'b0;
            par_reg         <= 1'b0;
            oe_reg          <= 1'b0;
        end else begin
            stage_valid_reg <= stage_valid_next;
            stage_reg       <= stage_next;
            ready_reg       <= ready_next;
            par_reg         <= par_next;
            oe_reg          <= oe_next;
        end
    end

    assign rx_out_valid      = stage_valid_reg;
    assign rx_char_out       = stage_reg.chr;
    assign rx_status_bus     = stage_reg.status;
    assign rx_in_ready       = ready_reg;
    assign rx_odd_parity_out = par_reg;
    assign rx_odd_parity_oe  = oe_reg;

    // ************************************************************
    // receive clock outputs and status
    // ************************************************************
    logic ref_ph_reg, ref_ph_next;
    logic rec_prev_reg, half_reg, half_next;
    logic clk_out_reg, clk_out_next, copy_reg, copy_next;
    logic eb_reg, err_reg, err_next;

    // reference phase is a one-cycle-delayed half-rate copy of clk;
    // a true clock cannot leave through a flop, so this is its image
    always_comb begin
        ref_ph_next = !ref_ph_reg;
        half_next   = (rec_sync && !rec_prev_reg) ? !half_reg : half_reg;
        clk_out_next = 1'b0;
        copy_next    = 1'b0;
        case (cfg_rxck_reg)
            TRI_LOW: begin
                clk_out_next = ref_ph_reg;                      // R7
                copy_next    = ref_ph_reg;                      // R7
            end
            TRI_MID: begin
                clk_out_next = (cfg_rate_reg == TRI_LOW) ? rec_sync
                                                         : half_reg; // R8
            end
            default: clk_out_next = 1'b0;
        endcase
        err_next = (bypass && cfg_rxck_reg != TRI_MID)
                || (cfg_rxck_reg == TRI_HIGH);          // R16 R4 R9
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ref_ph_reg   <= 1'b0;
            rec_prev_reg <= rec_sync;   // no false edge after reset
            half_reg     <= 1'b0;
            clk_out_reg  <= 1'b0;
            copy_reg     <= 1'b0;
            eb_reg       <= 1'b0;
            err_reg      <= 1'b0;
        end else begin
            ref_ph_reg   <= ref_ph_next;
            rec_prev_reg <= rec_sync;
            half_reg     <= half_next;
            clk_out_reg  <= clk_out_next;
            copy_reg     <= copy_next;
            eb_reg       <= eb_en;                              // R14
            err_reg      <= err_next;
        end
    end

    assign rx_char_clock_out     = clk_out_reg;
    assign rx_clock_copy_out     = copy_reg;
    assign elastic_buffer_enable = eb_reg;
    assign config_error          = err_reg;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_tx_par_high: assert property ( // R1
        (tx_valid && cfg_par_reg == TRI_HIGH) |=> tx_parity_error ==
        ~^{$past(tx_char), $past(tx_char_type), $past(tx_odd_parity_in)})
        else $error("tx parity check wrong in high setting");

    chk_rx_par_high: assert property ( // R2
        (cfg_par_reg == TRI_HIGH && rx_out_valid) |-> rx_odd_parity_oe &&
        (^{rx_char_out[7:0], rx_status_bus, rx_odd_parity_out}))
        else $error("rx parity not odd over char and status");

    chk_bypass_raw: assert property ( // R3
        (bypass && rx_in_valid && rx_in_ready) |=>
        rx_out_valid && rx_char_out == $past(rx_in.raw))
        else $error("bypass character was altered");

    chk_alt_table: assert property ( // R5
        (!eb_en && cfg_dec_reg == TRI_HIGH && rx_in_valid
         && rx_in_ready && rx_in.special && !rx_in.code_err) |=>
        rx_status_bus == ST_SPECIAL && rx_char_out[7:0] ==
        ALT_CODES[$past(rx_in.data[ALT_IDX_W-1:0])])
        else $error("alternate special table not applied");

    chk_ref_copy: assert property ( // R7
        (cfg_rxck_reg == TRI_LOW && $past(nrst)) |=>
        rx_char_clock_out != $past(rx_char_clock_out) &&
        rx_clock_copy_out == rx_char_clock_out)
        else $error("reference clock copies wrong");

    chk_eb_select: assert property ( // R8 R14
        $past(nrst) |-> elastic_buffer_enable ==
        (cfg_rxck_reg == TRI_LOW && cfg_dec_reg != TRI_LOW))
        else $error("elasticity buffer enable wrong");

    chk_float_mid: assert property ( // R11
        @(posedge clk) disable iff (1'b0)
        (!nrst && {s_par.sense_high, s_par.sense_low} == 2'b00)
        |=> cfg_par_reg == TRI_MID)
        else $error("floating pin did not read middle");

    chk_parity_hiz: assert property ( // R12
        (cfg_par_reg == TRI_LOW && $past(nrst)) |->
        !rx_odd_parity_oe && !tx_parity_error)
        else $error("parity active in low setting");

    chk_mid_parity: assert property ( // R13
        (cfg_par_reg == TRI_MID && !coding_off && tx_valid) |=>
        tx_parity_error == ~^{$past(tx_char), $past(tx_odd_parity_in)})
        else $error("middle parity check covers wrong bits");

    chk_cfg_hold: assert property ( // R15
        $past(nrst) |-> $stable(cfg_par_reg) && $stable(cfg_dec_reg)
        && $stable(cfg_rxck_reg))
        else $error("setting changed outside reset");

    chk_cfg_error: assert property ( // R16
        (cfg_rxck_reg == TRI_HIGH) |=> config_error [*2])
        else $error("invalid clock source not flagged");

endmodule // rxc_top
`default_nettype wire

// *** rxc_pkg.sv ***
// Purpose: shared types and constants for the receive-path config decoder
// Assumes: ternary pins arrive as two comparator senses (high and low)
// Notes:   a floating pin trips neither sense and reads as the middle level
`default_nettype none
package rxc_pkg;

    // ************************************************************
    // ternary settings and pin senses
    // ************************************************************
    typedef enum logic [1:0] {TRI_LOW, TRI_MID, TRI_HIGH} rxc_tern_type;

    typedef struct packed {
        logic sense_high;   // pin pulled near supply
        logic sense_low;    // pin pulled near ground
    } rxc_pin_type;

    // ************************************************************
    // receive characters
    // ************************************************************
    typedef struct packed {
        logic [9:0] raw;        // framed 10-bit character
        logic [7:0] data;       // decoded byte from the line decoder
        logic       special;    // byte is a special code
        logic       code_err;   // line decoder saw an illegal character
    } rxc_rxin_type;

    typedef struct packed {
        logic [9:0] chr;        // character presented to the host
        logic [2:0] status;     // receive status code
    } rxc_rxout_type;

    localparam int RXOUT_W    = 13;
    localparam int FIFO_DEPTH = 16;

    // status codes
    localparam logic [2:0] ST_DATA    = 3'h0;
    localparam logic [2:0] ST_SPECIAL = 3'h1;
    localparam logic [2:0] ST_CODEERR = 3'h7;

    // alternate special-code table, indexed by the low code bits
    localparam logic [7:0] ALT_CODES [0:7] = '{
        8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC, 8'hDC, 8'hFC
    };
    localparam int ALT_IDX_W = 3;

    // decode two senses into a setting; none or both reads as middle
    function automatic rxc_tern_type tern_decode(input rxc_pin_type p);
        rxc_tern_type t;
        t = TRI_MID;
        case ({p.sense_high, p.sense_low})
            2'b01:   t = TRI_LOW;
            2'b10:   t = TRI_HIGH;
            default: t = TRI_MID;
        endcase
        return t;
    endfunction

endpackage
`default_nettype wire

// *** rxc_fifo.sv ***
// Purpose: character buffer with valid/ready on both sides
// Assumes: single clock, synchronous active-low reset
// Notes:   level output lets the producer plan its ready one cycle ahead
`timescale 1ns/100ps
`default_nettype none
module rxc_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16,
    parameter int LVL_W = $clog2(DEPTH + 1)
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    // occupancy
    output logic [LVL_W-1:0]      level
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
    logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
    logic [LVL_W-1:0] level_reg, level_next;
    logic             push, pop;

    // honest flags straight from the occupancy count
    assign in_ready  = (level_reg != LVL_W'(DEPTH));
    assign out_valid = (level_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign level     = level_reg;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count update; pointers wrap at the depth
    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        level_next  = level_reg;
        if (push) begin
            wr_ptr_next = (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0
                        : PTR_W'(wr_ptr_reg + 1'b1);
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0
                        : PTR_W'(rd_ptr_reg + 1'b1);
        end
        if (push && !pop) begin
            level_next = LVL_W'(level_reg + 1'b1);
        end else if (pop && !push) begin
            level_next = LVL_W'(level_reg - 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            level_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            level_reg  <= level_next;
        end
    end

    // storage needs no reset; only written slots are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

endmodule // rxc_fifo
`default_nettype wire

// *** rxc_host_model.sv ***
// Purpose: host logic that takes receive characters from the block
// Assumes: ready moves just after the rising edge
// Notes:   stall holds ready low so the character buffer fills
`timescale 1ns/100ps
`default_nettype none
module rxc_host_model (
    // clock and bench control
    input  wire logic        clk,
    input  wire logic        stall,
    input  wire logic        clr,
    // character side
    input  wire logic        rx_out_valid,
    output logic             rx_out_ready,
    input  wire logic [9:0]  rx_char_out,
    input  wire logic [2:0]  rx_status_bus,
    input  wire logic        rx_odd_parity_out,
    // summary for the bench
    output logic [7:0]       got_cnt,
    output logic [15:0]      got_sum,
    output logic [13:0]      got_last
);
    initial begin
        rx_out_ready = 1'b0;
        got_cnt = 8'h00;
        got_sum = 16'h0000;
        got_last = 14'h0000;
    end
    // take a character on each edge where both sides agree
    always @(posedge clk) begin
        if (clr) begin
            got_cnt <= 8'h00;
            got_sum <= 16'h0000;
        end else if (rx_out_valid && rx_out_ready) begin
            got_cnt  <= got_cnt + 8'h01;
            got_sum  <= got_sum + {8'h00, rx_char_out[7:0]};
            got_last <= {rx_odd_parity_out, rx_status_bus, rx_char_out};
        end
        rx_out_ready <= #1 !stall;   // off the edge, like a real host
    end
endmodule // rxc_host_model
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the receive-path config decoder
// Assumes: settings are applied while reset is held; sc_bypass also moves pins after reset to check they are ignored
// Notes:   clk is the reference clock; sc_bypass drives the recovered clock pin by hand
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import rxc_pkg::*;
    logic clk, nrst, tx_valid, tx_parity_error, tx_odd_parity_in;
    logic rx_in_valid, rx_in_ready, rx_out_valid, rx_out_ready, ck_out;
    logic rx_odd_parity_out, rx_odd_parity_oe, ck_copy, eb_en, cfg_err;
    logic stall, clr, rec;
    rxc_pin_type pc, dm, rc, tm;
    logic [7:0] tx_char, got_cnt;
    logic [1:0] tx_char_type;
    logic [9:0] rx_char_out;
    logic [2:0] rx_status_bus;
    logic [15:0] got_sum;
    logic [13:0] got_last;
    rxc_rxin_type rx_in;
    int n_mismatch, checks;
    rxc_top i_dut (.clk(clk), .nrst(nrst), .parity_control_select(pc),
        .decoder_mode_select(dm), .rx_clock_source_select(rc),
        .tx_encoder_mode_select(tm), .recovered_clock_rate_select(2'h0),
        .recovered_clock_in(rec), .tx_char(tx_char),
        .tx_char_type(tx_char_type), .tx_odd_parity_in(tx_odd_parity_in),
        .tx_valid(tx_valid), .tx_parity_error(tx_parity_error),
        .rx_in(rx_in), .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready),
        .rx_char_out(rx_char_out), .rx_status_bus(rx_status_bus),
        .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
        .rx_odd_parity_out(rx_odd_parity_out),
        .rx_odd_parity_oe(rx_odd_parity_oe), .rx_char_clock_out(ck_out),
        .rx_clock_copy_out(ck_copy), .elastic_buffer_enable(eb_en),
        .config_error(cfg_err));
    rxc_host_model i_host (.clk(clk), .stall(stall), .clr(clr),
        .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
        .rx_char_out(rx_char_out), .rx_status_bus(rx_status_bus),
        .rx_odd_parity_out(rx_odd_parity_out), .got_cnt(got_cnt),
        .got_sum(got_sum), .got_last(got_last));
    // ************************************************************
    // helpers
    // ************************************************************
    task test_done;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // pins only move while reset is held, then stay put
    task cfg(input logic [1:0] p, input logic [1:0] d, input logic [1:0] r);
        nrst = 1'b0;
        pc = p;
        dm = d;
        rc = r;
        step(4);
        nrst = 1'b1;
        step(2);
    endtask
    // valid stays high between back-to-back calls; the caller lowers it after the last
    task tx(input logic [10:0] v, input logic e);
        {tx_char, tx_char_type, tx_odd_parity_in} = v;
        tx_valid = 1'b1;
        step(1);
        chk(tx_parity_error, e);
    endtask
    task rx(input logic [9:0] raw, input logic [7:0] d, input logic sp);
        int i;
        for (i = 0; i < 50 && rx_in_ready !== 1'b1; i++) step(1);
        if (i == 50) begin
            n_mismatch++;
            test_done;
        end
        rx_in = {raw, d, sp, 1'b0};
        rx_in_valid = 1'b1;
        step(1);
        rx_in_valid = 1'b0;
        step(3);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task sc_bypass;
        cfg(2'h2, 2'h1, 2'h0);
        chk({cfg_err, eb_en, ck_copy}, 16'h0000);
        rec = 1'b1;
        step(4);
        chk(ck_out, 1'b1);
        rec = 1'b0;
        step(4);
        chk(ck_out, 1'b1);
        tx({8'h01, 2'h0, 1'b0}, 1'b0);
        tx({8'h01, 2'h1, 1'b0}, 1'b1);
        tx_valid = 1'b0;
        rx(10'h3A5, 8'h00, 1'b1);
        chk(got_last, {~^{8'hA5, 3'h0}, 3'h0, 10'h3A5});
        pc = 2'h1;
        rc = 2'h2;
        step(4);
        chk({cfg_err, rx_odd_parity_oe}, 16'h0001);
    endtask
    task sc_buffered;
        int i, n;
        cfg(2'h0, 2'h0, 2'h1);
        chk({eb_en, cfg_err}, 16'h0002);
        tx({8'h01, 2'h1, 1'b0}, 1'b0);
        tx({8'h03, 2'h0, 1'b0}, 1'b1);
        tx_valid = 1'b0;
        chk(ck_copy, ck_out);
        i = ck_out;
        step(1);
        chk(ck_out, !i[0]);
        stall = 1'b1;
        clr = 1'b1;
        n = 0;
        step(1);
        clr = 1'b0;
        rx_in_valid = 1'b1;
        // data moves only after the buffer took the last one
        for (i = 0; i < 40; i++) begin
            rx_in = {2'h0, n[7:0], n[7:0], 1'b0, n == 16};
            if (rx_in_ready === 1'b1) n++;
            step(1);
        end
        rx_in_valid = 1'b0;
        chk({rx_in_ready, 1'(n >= 16)}, 16'h0001);
        stall = 1'b0;
        step(40);
        chk(got_cnt, n[15:0]);
        chk(got_sum, 16'(n * (n - 1) / 2));
        i = n - 1;
        chk({got_last[13:10], got_last[7:0]}, {~^i[7:0], 3'h7, i[7:0]});
        rx(10'h000, 8'h05, 1'b1);
        step(2);
        chk({got_last[12:10], got_last[7:0]}, {3'h1, 8'h05});
    endtask
    task sc_bad_cfg;
        cfg(2'h1, 2'h2, 2'h2);
        chk({cfg_err, rx_odd_parity_oe, eb_en}, 16'h0004);
        tx({8'h03, 2'h0, 1'b0}, 1'b0);
        tx_valid = 1'b0;
        rx(10'h000, 8'h05, 1'b1);
        chk({got_last[12:10], got_last[7:0]}, {3'h1, ALT_CODES[5]});
        chk({ck_out, ck_copy}, 16'h0000);
        cfg(2'h0, 2'h1, 2'h1);
        chk(cfg_err, 1'b1);
        tx({8'h01, 2'h1, 1'b0}, 1'b1);
        tx_valid = 1'b0;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // watchdog against a hang
    initial begin
        #200000;
        n_mismatch++;
        test_done;
    end
    initial begin
        n_mismatch = 0;
        checks = 0;
        {nrst, tx_valid, rx_in_valid, stall, clr} = 5'h00;
        {pc, dm, rc, tm, rec} = 9'h002; // encoder off all run
        {tx_char, tx_char_type, tx_odd_parity_in} = 11'h000;
        rx_in = '0;
        sc_bypass;
        sc_buffered;
        sc_bad_cfg;
        test_done;
    end
endmodule // tb_top
`default_nettype wire
